// >>> rtl/cwr_defs.svh
// Offsets, field positions, reset values and timing counts of the loader.
`ifndef CWR_DEFS_SVH
`define CWR_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define CWR_CFG_INDEX 16'h2007
`define CWR_STAT_INDEX 16'h2008
`define CWR_CTRL_INDEX 16'h2009

// Programmer address space.
`define CWR_PGM_MEM_TOP 14'h0FFF
`define CWR_PGM_ID_BASE 14'h2000
`define CWR_PGM_ID_LAST 14'h2003
`define CWR_PGM_CFG_ADDR 14'h2007

// Configuration word fields.
`define CWR_CFG_DBG_BIT 13
`define CWR_CFG_WRT_HI 11
`define CWR_CFG_WRT_LO 10
`define CWR_CFG_CP_BIT 6
`define CWR_CFG_PIN_BIT 5
`define CWR_CFG_POWERUP_DELAY_TIMER_BIT 4
`define CWR_CFG_WDT_BIT 3
`define CWR_CFG_UNIMPL_MASK 14'h1387
`define CWR_CFG_ERASED 14'h3FFF

// Self-write guard codes and protected tops.
`define CWR_WRT_NONE 2'b11
`define CWR_WRT_LOW1K 2'b10
`define CWR_WRT_LOW2K 2'b01
`define CWR_WRT_ALL 2'b00
`define CWR_WRT_TOP1K 12'h3FF
`define CWR_WRT_TOP2K 12'h7FF

// Status register fields.
`define CWR_STAT_POR_BIT 0
`define CWR_STAT_TO_BIT 1
`define CWR_STAT_PD_BIT 2

// Control register reset value: reset-pin filter length in cycles.
`define CWR_FILT_LEN_RST 8'h08

// Timing.
`define CWR_CLK_MHZ 10
`define CWR_POWERUP_DELAY_TIMER_US 64000
`define CWR_POWERUP_DELAY_TIMER_CYC (`CWR_POWERUP_DELAY_TIMER_US * `CWR_CLK_MHZ)
`define CWR_BIAS_US 10
`define CWR_BIAS_CYC (`CWR_BIAS_US * `CWR_CLK_MHZ)
`define CWR_OST_CYC 1024

`endif

// >>> rtl/cwr_pkg.sv
// Types shared by the configuration and reset control block.
package cwr_pkg;

  typedef enum logic [2:0] {
    ST_POR,
    ST_POWERUP_DELAY_TIMER,
    ST_OST,
    ST_PIN,
    ST_BIAS,
    ST_RESET,
    ST_WAKE,
    ST_RUN
  } cwr_state_t;

  typedef struct packed {
    logic debugEnable;
    logic [1:0] selfWriteGuardField;
    logic readoutProtect;
    logic resetPinSelect;
    logic powerupDelayEnable;
    logic watchdogEnable;
  } cwr_cfg_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [13:0] addr;
    logic [13:0] data;
  } cwr_pgm_req_t;

  typedef struct packed {
    logic en;
    logic [11:0] addr;
    logic [13:0] data;
  } cwr_mem_wr_t;

endpackage : cwr_pkg

// >>> rtl/cwr_pulse_filter.sv
// Reset pin synchroniser and glitch filter.
`timescale 1ns/100ps
module cwr_pulse_filter #(
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pin and filter setting
  input wire logic pinRaw,
  input wire logic [LEN_W-1:0] filterLen,
  // Filtered level
  output logic levelOut
);
  generate
    if (LEN_W < 1) begin : g_bad_len
      $error("cwr_pulse_filter: LEN_W must be at least 1");
    end
  endgenerate

  logic sync1_q;
  logic sync2_q;
  logic level_q;
  logic [LEN_W-1:0] cnt_q;
  wire differs = sync2_q != level_q;
  wire settled = cnt_q >= filterLen;

  // A change must persist for filterLen + 1 cycles before it is passed on.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      level_q <= 1'b1;
      cnt_q <= '0;
    end else begin
      sync1_q <= pinRaw;
      sync2_q <= sync1_q;
      if (!differs) begin
        cnt_q <= '0;
      end else if (settled) begin
        level_q <= sync2_q;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign levelOut = level_q;
endmodule : cwr_pulse_filter

// >>> rtl/cwr_delay_timer.sv
// Loadable down counter shared by the reset sequence delays.
`timescale 1ns/100ps
module cwr_delay_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Load
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  // Status
  output logic expired
);
  generate
    if (W < 2) begin : g_bad_w
      $error("cwr_delay_timer: W must be at least 2");
    end
  endgenerate

  logic [W-1:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= loadValue;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = cnt_q == '0;
endmodule : cwr_delay_timer

// >>> rtl/cwr_top.sv
// Configuration word decode, code protection and reset sequencing.
//
// Function
// - Configuration word is 14 bits at program address 2007h.
// - Bit 13 high disables debug mode; low enables it.
// - Guard 11 none, 10 to 3FFh, 01 to 7FFh, 00 all memory.
// - Unimplemented bits 12, 9-7 and 2-0 read as one.
// - Protect bit low blocks programmer writes to and zeroes programmer reads of program memory.
// - Core fetch unaffected by protection; self-writes obey only the guard.
// - Bit 5 set makes pin active-low reset with pull-up; else alternate use.
// - Bit 4 high disables the power-up delay; low enables it.
// - Bit 3 high enables the watchdog; low disables it.
// - Four ID words at 2000h-2003h, reachable only in program mode.
// - Reset from power-on, overtemperature, reset pin or watchdog time-out.
// - Power-up delay lengthens only the reset following power-on.
// - Power-on, pin and watchdog resets load register reset values.
// - Watchdog wake-up resumes without register reset values.
// - Timeout and sleep flags update on power-on, watchdog, sleep entry and pin reset in sleep.
// - Short pulses on the reset pin are filtered out.
// - After wake-up or power-on execution waits about 10 us.
// - Power-up delay holds reset 64 ms after power-on only.
// - Start waits for power-up delay, oscillator start and pin release.
// - Watchdog reset acts internally and never drives the reset pin.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
`include "cwr_defs.svh"
module cwr_top #(
  parameter int POWERUP_DELAY_TIMER_CYCLES = `CWR_POWERUP_DELAY_TIMER_CYC,
  parameter int OST_CYCLES = `CWR_OST_CYC,
  parameter int BIAS_CYCLES = `CWR_BIAS_CYC,
  parameter int TMR_W = 20
) (
  // Clock and power-on reset
  input wire logic core_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [15:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Nonvolatile configuration word from the array
  input wire logic [13:0] nvConfigWord,
  // Reset sources
  input wire logic externalResetPinN,
  input wire logic thermalTripReset,
  input wire logic watchdogTimeout,
  input wire logic sleepActive,
  // External programmer
  input wire logic progMode,
  input wire cwr_pkg::cwr_pgm_req_t pgmReq,
  input wire logic [13:0] memRdData,
  output logic [13:0] pgmRData,
  output logic pgmAck,
  output cwr_pkg::cwr_mem_wr_t memWr,
  // Core self-write check
  input wire logic selfWrReq,
  input wire logic [11:0] selfWrAddr,
  output logic selfWrGrant,
  output logic selfWrDeny,
  // Decoded configuration and reset control
  output cwr_pkg::cwr_cfg_t cfgOut,
  output logic resetPinPullupEn,
  output logic altPinLevel,
  output logic coreResetHold,
  output logic regInit
);
  generate
    if (TMR_W < 2 || POWERUP_DELAY_TIMER_CYCLES < 1 || OST_CYCLES < 1 ||
        BIAS_CYCLES < 1 || POWERUP_DELAY_TIMER_CYCLES >= (1 << TMR_W) ||
        OST_CYCLES >= (1 << TMR_W) || BIAS_CYCLES >= (1 << TMR_W)) begin
      : g_bad_cnt
      $error("cwr_top: delay counts must be positive and fit TMR_W");
    end
  endgenerate

  function automatic logic [15:0] byteAddr(input logic [15:0] idx);
    byteAddr = {idx[13:0], 2'b00};
  endfunction : byteAddr

  function automatic logic guarded(input logic [1:0] field,
                                   input logic [11:0] addr);
    unique case (field)
      `CWR_WRT_NONE: guarded = 1'b0;
      `CWR_WRT_LOW1K: guarded = addr <= `CWR_WRT_TOP1K;
      `CWR_WRT_LOW2K: guarded = addr <= `CWR_WRT_TOP2K;
      `CWR_WRT_ALL: guarded = 1'b1;
    endcase
  endfunction : guarded

  cwr_pkg::cwr_state_t state_q;
  cwr_pkg::cwr_state_t state_d;
  logic [13:0] cfgWord_q;
  cwr_pkg::cwr_cfg_t cfg_q;
  logic porFlagN_q;
  logic timeoutFlag_q;
  logic sleepEnteredFlagN_q;
  logic [7:0] filterLen_q;
  logic thermSync1_q;
  logic thermSync2_q;
  logic sleepPrev_q;
  logic [31:0] wbDatR_q;
  logic wbAck_q;
  logic [13:0] pgmRData_q;
  logic pgmAck_q;
  cwr_pkg::cwr_mem_wr_t memWr_q;
  logic selfWrGrant_q;
  logic selfWrDeny_q;
  logic resetPinPullupEn_q;
  logic altPinLevel_q;
  logic coreResetHold_q;
  logic regInit_q;
  logic [13:0] idWord_q [4];
  logic pinLevel;
  logic tmrExpired;

  wire [13:0] nvWordFixed = nvConfigWord | `CWR_CFG_UNIMPL_MASK;

  cwr_pulse_filter #(
    .LEN_W(8)
  ) u_filter (
    .core_clk(core_clk),
    .rst(rst),
    .pinRaw(externalResetPinN),
    .filterLen(filterLen_q),
    .levelOut(pinLevel)
  );

  wire pinReset = cfg_q.resetPinSelect & ~pinLevel;
  wire thermal = thermSync2_q;
  wire wdtEvent = watchdogTimeout & cfg_q.watchdogEnable;
  wire asleep = sleepActive;
  wire running = state_q == cwr_pkg::ST_RUN;
  wire sleepEnter = sleepActive & ~sleepPrev_q;

  wire evPinRst = running & pinReset;
  wire evThermRst = running & ~pinReset & thermal;
  wire evWdtWake = running & ~pinReset & ~thermal & wdtEvent & asleep;
  wire evWdtRst = running & ~pinReset & ~thermal & wdtEvent & ~asleep;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cwr_pkg::ST_POR: begin
        // power-up delay only on the power-on path
        // The decoded copy is still loading here, so read the raw bit.
        state_d = !nvConfigWord[`CWR_CFG_POWERUP_DELAY_TIMER_BIT] ? cwr_pkg::ST_POWERUP_DELAY_TIMER
                                                    : cwr_pkg::ST_OST;
      end
      cwr_pkg::ST_POWERUP_DELAY_TIMER: begin
        if (tmrExpired) begin
          state_d = cwr_pkg::ST_OST;
        end
      end
      cwr_pkg::ST_OST: begin
        if (tmrExpired) begin
          state_d = cwr_pkg::ST_PIN;
        end
      end
      cwr_pkg::ST_PIN: begin
        // wait for pin release after the timers
        if (!pinReset && !thermal) begin
          state_d = cwr_pkg::ST_BIAS;
        end
      end
      cwr_pkg::ST_BIAS: begin
        if (tmrExpired) begin
          state_d = cwr_pkg::ST_RUN;
        end
      end
      cwr_pkg::ST_RESET: begin
        if (!pinReset && !thermal) begin
          state_d = cwr_pkg::ST_RUN;
        end
      end
      cwr_pkg::ST_WAKE: begin
        if (pinReset || thermal) begin
          state_d = cwr_pkg::ST_RESET;
        end else if (tmrExpired) begin
          state_d = cwr_pkg::ST_RUN;
        end
      end
      cwr_pkg::ST_RUN: begin
        if (evPinRst || evThermRst || evWdtRst) begin
          state_d = cwr_pkg::ST_RESET;
        end else if (evWdtWake) begin
          state_d = cwr_pkg::ST_WAKE;
        end
      end
    endcase
  end

  // power-up delay count; bias settle count
  wire enterTimed = (state_d != state_q) &&
                    (state_d == cwr_pkg::ST_POWERUP_DELAY_TIMER ||
                     state_d == cwr_pkg::ST_OST ||
                     state_d == cwr_pkg::ST_BIAS ||
                     state_d == cwr_pkg::ST_WAKE);
  wire [TMR_W-1:0] tmrLoadValue =
    (state_d == cwr_pkg::ST_POWERUP_DELAY_TIMER) ? TMR_W'(POWERUP_DELAY_TIMER_CYCLES) :
    (state_d == cwr_pkg::ST_OST) ? TMR_W'(OST_CYCLES) :
    TMR_W'(BIAS_CYCLES);

  cwr_delay_timer #(
    .W(TMR_W)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .load(enterTimed),
    .loadValue(tmrLoadValue),
    .expired(tmrExpired)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= cwr_pkg::ST_POR;
      thermSync1_q <= 1'b0;
      thermSync2_q <= 1'b0;
      sleepPrev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      thermSync1_q <= thermalTripReset;
      thermSync2_q <= thermSync1_q;
      sleepPrev_q <= sleepActive;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfgWord_q <= `CWR_CFG_ERASED;
      cfg_q <= '0;
    end else if (state_q == cwr_pkg::ST_POR) begin
      cfgWord_q <= nvWordFixed;
      // debug enable is the inverse of the disable bit
      cfg_q.debugEnable <= ~nvConfigWord[`CWR_CFG_DBG_BIT];
      cfg_q.selfWriteGuardField <=
        nvConfigWord[`CWR_CFG_WRT_HI:`CWR_CFG_WRT_LO];
      cfg_q.readoutProtect <= ~nvConfigWord[`CWR_CFG_CP_BIT];
      cfg_q.resetPinSelect <= nvConfigWord[`CWR_CFG_PIN_BIT];
      // delay enabled when the bit is low
      cfg_q.powerupDelayEnable <= ~nvConfigWord[`CWR_CFG_POWERUP_DELAY_TIMER_BIT];
      // watchdog enabled when the bit is high
      cfg_q.watchdogEnable <= nvConfigWord[`CWR_CFG_WDT_BIT];
    end
  end

  // Wishbone decode.
  wire wbReq = wbCyc & wbStb & ~wbAck_q;
  wire hitCfg = wbAdr == byteAddr(`CWR_CFG_INDEX);
  wire hitStat = wbAdr == byteAddr(`CWR_STAT_INDEX);
  wire hitCtrl = wbAdr == byteAddr(`CWR_CTRL_INDEX);
  wire wrStat = wbReq & wbWe & hitStat & wbSel[0];
  wire wrCtrl = wbReq & wbWe & hitCtrl & wbSel[0];
  wire [31:0] statWord = {29'h0000_0000, sleepEnteredFlagN_q,
                          timeoutFlag_q, porFlagN_q};
  wire [31:0] rdMux = hitCfg ? {18'h0_0000, cfgWord_q} :
                      hitStat ? statWord :
                      hitCtrl ? {24'h00_0000, filterLen_q} :
                      32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wbAck_q <= 1'b0;
      wbDatR_q <= 32'h0000_0000;
      filterLen_q <= `CWR_FILT_LEN_RST;
    end else begin
      wbAck_q <= wbReq;
      wbDatR_q <= wbReq ? rdMux : 32'h0000_0000;
      if (wrCtrl) begin
        filterLen_q <= wbDatW[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      porFlagN_q <= 1'b0;
      timeoutFlag_q <= 1'b1;
      sleepEnteredFlagN_q <= 1'b1;
    end else begin
      if (wrStat) begin
        porFlagN_q <= wbDatW[`CWR_STAT_POR_BIT];
      end
      if (evWdtRst) begin
        timeoutFlag_q <= 1'b0;
      end else if (evWdtWake) begin
        timeoutFlag_q <= 1'b0;
        sleepEnteredFlagN_q <= 1'b0;
      end else if (evPinRst && asleep) begin
        timeoutFlag_q <= 1'b1;
        sleepEnteredFlagN_q <= 1'b0;
      end else if (sleepEnter && running) begin
        timeoutFlag_q <= 1'b1;
        sleepEnteredFlagN_q <= 1'b0;
      end
    end
  end

  // Programmer access, refused outside program mode.
  wire pgmGo = progMode & pgmReq.valid & running;
  wire pgmMem = pgmReq.addr <= `CWR_PGM_MEM_TOP;
  wire pgmId = pgmReq.addr >= `CWR_PGM_ID_BASE &&
               pgmReq.addr <= `CWR_PGM_ID_LAST;
  wire pgmCfg = pgmReq.addr == `CWR_PGM_CFG_ADDR;
  wire [1:0] idSel = pgmReq.addr[1:0];
  wire [13:0] pgmMux = pgmMem ? (cfg_q.readoutProtect ? 14'h0000
                                                      : memRdData) :
                       pgmId ? idWord_q[idSel] :
                       pgmCfg ? cfgWord_q : 14'h0000;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pgmAck_q <= 1'b0;
      pgmRData_q <= 14'h0000;
      memWr_q <= '0;
    end else begin
      pgmAck_q <= pgmGo;
      pgmRData_q <= (pgmGo && !pgmReq.we) ? pgmMux : 14'h0000;
      memWr_q.en <= pgmGo & pgmReq.we & pgmMem & ~cfg_q.readoutProtect;
      memWr_q.addr <= pgmReq.addr[11:0];
      memWr_q.data <= pgmReq.data;
    end
  end

  // ID words written only in program mode
  always_ff @(posedge core_clk) begin
    if (pgmGo && pgmReq.we && pgmId) begin
      idWord_q[idSel] <= pgmReq.data;
    end
  end

  // self-write checked against the guard alone
  wire selfGuarded = guarded(cfg_q.selfWriteGuardField, selfWrAddr);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      selfWrGrant_q <= 1'b0;
      selfWrDeny_q <= 1'b0;
      resetPinPullupEn_q <= 1'b0;
      altPinLevel_q <= 1'b1;
      coreResetHold_q <= 1'b1;
      regInit_q <= 1'b1;
    end else begin
      selfWrGrant_q <= selfWrReq & running & ~selfGuarded;
      selfWrDeny_q <= selfWrReq & (~running | selfGuarded);
      resetPinPullupEn_q <= cfg_q.resetPinSelect;
      altPinLevel_q <= cfg_q.resetPinSelect ? 1'b1 : pinLevel;
      coreResetHold_q <= state_d != cwr_pkg::ST_RUN;
      // register init on resets; not on wake
      regInit_q <= state_d != cwr_pkg::ST_RUN &&
                   state_d != cwr_pkg::ST_WAKE;
    end
  end

  // reset pin is input only, never driven here
  assign wbDatR = wbDatR_q;
  assign wbAck = wbAck_q;
  assign pgmRData = pgmRData_q;
  assign pgmAck = pgmAck_q;
  assign memWr = memWr_q;
  assign selfWrGrant = selfWrGrant_q;
  assign selfWrDeny = selfWrDeny_q;
  assign cfgOut = cfg_q;
  assign resetPinPullupEn = resetPinPullupEn_q;
  assign altPinLevel = altPinLevel_q;
  assign coreResetHold = coreResetHold_q;
  assign regInit = regInit_q;
endmodule : cwr_top

// >>> dv/cwr_top_asserts.sv
// Concurrent checks on the loader's top-level ports.
`timescale 1ns/100ps
module cwr_top_asserts #(
  parameter int POWERUP_DELAY_TIMER_CYCLES = 40
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [15:0] wbAdr,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  // Events
  input wire logic watchdogTimeout,
  input wire logic sleepActive,
  // Programmer
  input wire logic progMode,
  input wire cwr_pkg::cwr_pgm_req_t pgmReq,
  input wire logic pgmAck,
  input wire logic [13:0] pgmRData,
  input wire cwr_pkg::cwr_mem_wr_t memWr,
  // Self-write
  input wire logic selfWrReq,
  input wire logic [11:0] selfWrAddr,
  input wire logic selfWrGrant,
  input wire logic selfWrDeny,
  // Decoded outputs
  input wire cwr_pkg::cwr_cfg_t cfgOut,
  input wire logic resetPinPullupEn,
  input wire logic coreResetHold,
  input wire logic regInit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic porPhase_q;
  logic [23:0] porCnt_q;
  wire logic [1:0] guard = cfgOut.selfWriteGuardField;
  wire logic guardHit = (guard == 2'b00) ||
    (guard == 2'b01 && selfWrAddr <= 12'h7FF) ||
    (guard == 2'b10 && selfWrAddr <= 12'h3FF);
  // Counts cycles from power-on release; porPhase_q stays high until the core first runs.
  always_ff @(posedge core_clk) begin
    porPhase_q <= rst || (porPhase_q && coreResetHold);
    porCnt_q <= rst ? '0 : porCnt_q + 24'h1;
  end
  property p_cfg_unimpl;
    wbCyc && wbStb && !wbAck && !wbWe && wbAdr == 16'h801C |=>
      (wbDatR & 32'h0000_1387) == 32'h0000_1387;
  endproperty
  a_cfg_unimpl: assert property (p_cfg_unimpl) else $error("cfg bits");
  property p_pullup;
    !coreResetHold |-> resetPinPullupEn == cfgOut.resetPinSelect;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up");
  property p_cp_read;
    pgmReq.valid && progMode && !coreResetHold && !pgmReq.we &&
      pgmReq.addr <= 14'h0FFF && cfgOut.readoutProtect |=>
      pgmAck && pgmRData == 14'h0;
  endproperty
  a_cp_read: assert property (p_cp_read) else $error("cp read");
  property p_cp_write;
    memWr.en |-> !cfgOut.readoutProtect;
  endproperty
  a_cp_write: assert property (p_cp_write) else $error("cp write");
  property p_prog_mode;
    pgmReq.valid && !progMode |=> !pgmAck;
  endproperty
  a_prog_mode: assert property (p_prog_mode) else $error("prog");
  property p_self_wr;
    selfWrReq && !coreResetHold |=>
      selfWrDeny == $past(guardHit) && selfWrGrant == !$past(guardHit);
  endproperty
  a_self_wr: assert property (p_self_wr) else $error("self write");
  property p_cfg_hold;
    !coreResetHold |=> $stable(cfgOut);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved");
  property p_wdt_rst;
    watchdogTimeout && cfgOut.watchdogEnable && !sleepActive &&
      !coreResetHold |=> regInit && coreResetHold ##1 !coreResetHold;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("wdt reset");
  property p_wdt_wake;
    watchdogTimeout && cfgOut.watchdogEnable && sleepActive &&
      !coreResetHold |=> (coreResetHold && !regInit) [*2];
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("wake");
  property p_powerup_delay_timer;
    porPhase_q && !coreResetHold && cfgOut.powerupDelayEnable |->
      porCnt_q >= 24'(POWERUP_DELAY_TIMER_CYCLES);
  endproperty
  a_powerup_delay_timer: assert property (p_powerup_delay_timer) else $error("power-up delay");
endmodule : cwr_top_asserts

// >>> dv/cwr_far_model.sv
// Program memory and reset pin as seen from outside the loader.
`timescale 1ns/100ps
module cwr_far_model (
  // Clock
  input wire logic core_clk,
  // Memory side
  input wire logic [13:0] rdAddr,
  input wire cwr_pkg::cwr_mem_wr_t memWr,
  output logic [13:0] memRdData,
  // Pin side
  input wire logic pinDriveLow,
  input wire logic pullupEn,
  output logic pinN
);
  logic [13:0] mem [0:4095];
  logic floatLvl_q = 1'b0;
  assign pinN = pinDriveLow ? 1'b0 : (pullupEn ? 1'b1 : floatLvl_q);
  assign memRdData = mem[rdAddr[11:0]];
  // An undriven pin without pull-up wanders, so it toggles every cycle.
  always @(posedge core_clk) begin
    floatLvl_q <= ~floatLvl_q;
    if (memWr.en) mem[memWr.addr] <= memWr.data;
  end
endmodule : cwr_far_model

// >>> dv/testbench.sv
// Self-checking bench for the configuration and reset control block.
`timescale 1ns/100ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("ERROR %0t got %h expected %h", $time, (g), (e)); \
  end \
end
module testbench;
  localparam int POWERUP_DELAY_TIMER = 40;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [3:0] wbSel = 4'h0;
  logic [15:0] wbAdr = 16'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR, rd;
  logic [13:0] nvConfigWord = 14'h3FFF, memRdData, pgmRData, pRd, cfg;
  logic extPinN, pinDriveLow = 1'b0, thermalTripReset = 1'b0;
  logic watchdogTimeout = 1'b0, sleepActive = 1'b0, progMode = 1'b0;
  logic pgmAck, selfWrReq = 1'b0, selfWrGrant, selfWrDeny;
  logic [11:0] selfWrAddr = 12'h0;
  logic resetPinPullupEn, altPinLevel, coreResetHold, regInit;
  logic pAck, pWr, hi, ri, hiSeen, porM, toM, pdM;
  logic [1:0] sgd;
  logic [31:0] lfsr_q = 32'h1a7c_96a0;
  cwr_pkg::cwr_pgm_req_t pgmReq = '0;
  cwr_pkg::cwr_mem_wr_t memWr;
  cwr_pkg::cwr_cfg_t cfgOut;
  logic [13:0] cfgTab [4] = '{14'h2828, 14'h0450, 14'h2078, 14'h3FFF};
  logic [11:0] bnd [4] = '{12'h3FF, 12'h400, 12'h7FF, 12'h800};
  int mismatches = 0, total_checks = 0, n;

  cwr_top #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER), .OST_CYCLES(4), .BIAS_CYCLES(3)) uut (
    .core_clk(core_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
    .wbDatR(wbDatR), .wbAck(wbAck), .nvConfigWord(nvConfigWord),
    .externalResetPinN(extPinN), .thermalTripReset(thermalTripReset),
    .watchdogTimeout(watchdogTimeout), .sleepActive(sleepActive),
    .progMode(progMode), .pgmReq(pgmReq), .memRdData(memRdData),
    .pgmRData(pgmRData), .pgmAck(pgmAck), .memWr(memWr),
    .selfWrReq(selfWrReq), .selfWrAddr(selfWrAddr),
    .selfWrGrant(selfWrGrant), .selfWrDeny(selfWrDeny), .cfgOut(cfgOut),
    .resetPinPullupEn(resetPinPullupEn), .altPinLevel(altPinLevel),
    .coreResetHold(coreResetHold), .regInit(regInit));
  cwr_far_model far (.core_clk(core_clk), .rdAddr(pgmReq.addr),
    .memWr(memWr), .memRdData(memRdData), .pinDriveLow(pinDriveLow),
    .pullupEn(resetPinPullupEn), .pinN(extPinN));

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsrNext
  function automatic cwr_pkg::cwr_cfg_t expCfg(input logic [13:0] c);
    return {~c[13], c[11:10], ~c[6], c[5], ~c[4], c[3]};
  endfunction : expCfg
  function automatic logic guarded(input logic [11:0] a);
    return cfg[11:10] == 2'b00 || (cfg[11:10] == 2'b01 && a <= 12'h7FF)
      || (cfg[11:10] == 2'b10 && a <= 12'h3FF);
  endfunction : guarded
  function automatic logic [31:0] stat();
    return {29'h0, pdM, toM, porM};
  endfunction : stat

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask : tick
  task automatic waitRun();
    n = 0;
    while (coreResetHold !== 1'b0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) mismatches++;
  endtask : waitRun
  task automatic wb(input logic we, input logic [15:0] a,
                    input logic [31:0] d);
    int k = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hF;
    wbAdr <= a;
    wbDatW <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    tick(1);
  endtask : wb
  task automatic pg(input logic we, input logic [13:0] a,
                    input logic [13:0] d);
    pgmReq <= {1'b1, we, a, d};
    tick(1);
    pgmReq <= '0;
    tick(1);
    pAck = pgmAck;
    pRd = pgmRData;
    pWr = memWr.en;
  endtask : pg
  task automatic selfWr(input logic [11:0] a);
    selfWrReq <= 1'b1;
    selfWrAddr <= a;
    tick(1);
    selfWrReq <= 1'b0;
    tick(1);
    sgd = {selfWrGrant, selfWrDeny};
  endtask : selfWr
  task automatic wdPulse();
    watchdogTimeout <= 1'b1;
    tick(1);
    watchdogTimeout <= 1'b0;
    tick(1);
    hi = coreResetHold;
    ri = regInit;
  endtask : wdPulse
  task automatic pulseSrc(input logic thermal, input int k);
    hiSeen = 1'b0;
    if (thermal) thermalTripReset <= 1'b1;
    else pinDriveLow <= 1'b1;
    for (int c = 0; c < k + 20; c++) begin
      @(posedge core_clk);
      hiSeen |= coreResetHold;
      if (c == k - 1) {thermalTripReset, pinDriveLow} <= 2'b00;
    end
    waitRun();
  endtask : pulseSrc
  task automatic powerOn(input logic [13:0] c);
    lfsr_q = lfsrNext(lfsr_q);
    cfg = c | (lfsr_q[13:0] & 14'h1387);
    rst <= 1'b1;
    nvConfigWord <= cfg;
    tick(4);
    rst <= 1'b0;
    {porM, toM, pdM} = 3'b011;
    waitRun();
  endtask : powerOn
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  initial begin
    tick(20000);
    mismatches++;
    end_sim();
  end

  initial begin
    foreach (cfgTab[i]) begin
      powerOn(cfgTab[i]);
      `CHK(n >= POWERUP_DELAY_TIMER, !cfg[4])
      `CHK(cfgOut, expCfg(cfg))
      `CHK(resetPinPullupEn, cfg[5])
      `CHK(altPinLevel, 1'b1)
      wb(1'b0, 16'h801C, 32'h0);
      `CHK(rd, {18'h0, cfg | 14'h1387})
      wb(1'b0, 16'h8020, 32'h0);
      `CHK(rd, stat())
      foreach (bnd[j]) begin
        selfWr(bnd[j]);
        `CHK(sgd, {~guarded(bnd[j]), guarded(bnd[j])})
      end
      progMode <= 1'b1;
      lfsr_q = lfsrNext(lfsr_q);
      pg(1'b1, 14'h0123, lfsr_q[13:0]);
      `CHK(pWr, cfg[6])
      pg(1'b0, 14'h0123, 14'h0);
      `CHK(pRd, cfg[6] ? lfsr_q[13:0] : 14'h0)
      pg(1'b1, 14'h2000 + 14'(i), ~lfsr_q[13:0]);
      pg(1'b0, 14'h2000 + 14'(i), 14'h0);
      `CHK(pRd, ~lfsr_q[13:0])
      progMode <= 1'b0;
      pg(1'b0, 14'h2000, 14'h0);
      `CHK(pAck, 1'b0)
      wdPulse();
      `CHK({hi, ri}, {cfg[3], cfg[3]})
      if (cfg[3]) toM = 1'b0;
      waitRun();
      $display("power-on case %0d done", i);
    end
    wb(1'b1, 16'h8020, 32'h1);
    porM = 1'b1;
    wb(1'b0, 16'h8024, 32'h0);
    `CHK(rd, 32'h8)
    wb(1'b0, 16'h8100, 32'h0);
    `CHK(rd, 32'h0)
    pulseSrc(1'b0, 3);
    `CHK(hiSeen, 1'b0)
    pulseSrc(1'b0, 20);
    `CHK(hiSeen, 1'b1)
    pulseSrc(1'b1, 10);
    `CHK(hiSeen, 1'b1)
    wb(1'b0, 16'h8020, 32'h0);
    `CHK(rd, stat())
    $display("pin and thermal resets done");
    sleepActive <= 1'b1;
    tick(2);
    {toM, pdM} = 2'b10;
    wdPulse();
    `CHK({hi, ri}, 2'b10)
    toM = 1'b0;
    sleepActive <= 1'b0;
    waitRun();
    wb(1'b0, 16'h8020, 32'h0);
    `CHK(rd, stat())
    sleepActive <= 1'b1;
    pulseSrc(1'b0, 20);
    {toM, pdM} = 2'b10;
    sleepActive <= 1'b0;
    wb(1'b0, 16'h8020, 32'h0);
    `CHK(rd, stat())
    $display("sleep cases done");
    end_sim();
  end
endmodule : testbench

bind cwr_top cwr_top_asserts #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) chk (
  .core_clk(core_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
  .wbWe(wbWe), .wbAdr(wbAdr), .wbDatR(wbDatR), .wbAck(wbAck),
  .watchdogTimeout(watchdogTimeout), .sleepActive(sleepActive),
  .progMode(progMode), .pgmReq(pgmReq), .pgmAck(pgmAck),
  .pgmRData(pgmRData), .memWr(memWr), .selfWrReq(selfWrReq),
  .selfWrAddr(selfWrAddr), .selfWrGrant(selfWrGrant),
  .selfWrDeny(selfWrDeny), .cfgOut(cfgOut),
  .resetPinPullupEn(resetPinPullupEn), .coreResetHold(coreResetHold),
  .regInit(regInit));
